// [shared/acr_pkg.sv]
// Package of offsets, field positions, reset values and states for the converter control block.
package acr_pkg;
  // Register byte offsets on the APB port.
  localparam logic [7:0] OFF_CTRL_TWO = 8'h00;
  localparam logic [7:0] OFF_CTRL_THREE = 8'h04;
  localparam logic [7:0] OFF_TRIG_MODE = 8'h08;
  localparam logic [7:0] OFF_MODULE_CTRL = 8'h0C;
  // Field positions in control register two.
  localparam int CT2_READY = 31;
  localparam int CT2_FAULT = 30;
  localparam int CT2_SCAN = 29;
  localparam int CT2_CAP_LO = 26;
  localparam int CT2_SW_SAMPLE_HOLD_LO = 16;
  localparam int CT2_READY_IE = 15;
  localparam int CT2_FAULT_IE = 14;
  localparam int CT2_SCAN_IE = 13;
  localparam int CT2_EXT_EN = 11;
  // Field positions in control register three.
  localparam int CT3_SRC_LO = 30;
  localparam int CT3_CDIV_LO = 24;
  localparam int CT3_SHARED_EN = 23;
  localparam int CT3_DED_EN = 16;
  localparam int CT3_REF_LO = 13;
  localparam int CT3_SUSPEND = 12;
  localparam int CT3_UPD_IE = 11;
  localparam int CT3_UPD_RDY = 10;
  localparam int CT3_SAMPLE = 9;
  localparam int CT3_REQUEST = 8;
  localparam int CT3_LEVEL_TRG = 7;
  localparam int CT3_EDGE_TRG = 6;
  // Field positions in the dedicated core trigger mode register.
  localparam int TM_ALT_LO = 16;
  localparam int TM_PRESYNC = 8;
  localparam int TM_SYNC_SW_SAMPLE_HOLD = 0;
  // Writable masks, with hardware-owned and unimplemented bits cleared.
  localparam logic [31:0] CT2_WMASK = 32'h1FFF_E87F;
  localparam logic [31:0] CT3_WMASK = 32'hFF81_FBFF;
  localparam logic [31:0] TM_WMASK = 32'h0003_0101;
  // Value of every register after reset.
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  // Supply reference code and dedicated core input selection codes.
  localparam logic [2:0] REF_SUPPLY = 3'h0;
  localparam logic [1:0] ALT_INPUT_ZERO = 2'h0;
  localparam logic [1:0] ALT_INPUT_HIGH = 2'h1;
  localparam logic [5:0] DED_INPUT_ZERO = 6'h00;
  localparam logic [5:0] DED_INPUT_HIGH = 6'h2D;
  // Converter clock source codes.
  typedef enum logic [1:0] {
    ACR_SRC_PBUS = 2'h0,
    ACR_SRC_FRC = 2'h1,
    ACR_SRC_REFO = 2'h2,
    ACR_SRC_SYS = 2'h3
  } acr_src_e;
  // Shared core sampling state, Gray coded along idle, sample, convert.
  typedef enum logic [1:0] {
    ACR_IDLE = 2'b00,
    ACR_SAMPLE = 2'b01,
    ACR_CONVERT = 2'b11
  } acr_state_e;
endpackage : acr_pkg

// [shared/acr_tick_if.sv]
// Interface carrying the divider settings and the tick between divider instances and the top.
`timescale 1ns/1ns
interface acr_tick_if;
  logic [6:0] ratio;  // Divide ratio minus one.
  logic enable;       // Divider runs while high.
  logic tick;         // One-cycle pulse at each divided period.
  modport divider (input ratio, input enable, output tick);
  modport user (output ratio, output enable, input tick);
endinterface : acr_tick_if

// [hw/acr_divider.sv]
// Programmable tick divider producing one pulse every ratio plus one input cycles.
`timescale 1ns/1ns
module acr_divider
(
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Settings and tick.
  acr_tick_if.divider tk
);
  logic [6:0] count_reg;  // Cycles left in the present period.
  logic [6:0] count_next;
  // Hold the count while the enable is low, so that a divider fed by pulses still advances.
  assign count_next = !tk.enable ? count_reg :
    (count_reg == 7'h00) ? tk.ratio : count_reg - 7'h01;
  assign tk.tick = tk.enable && count_reg == 7'h00;
  // Count register.
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      count_reg <= 7'h00;
    else
      count_reg <= count_next;
  end
endmodule : acr_divider

// [hw/acr_sample_timer.sv]
// Down counter that times the shared core sampling window.
`timescale 1ns/1ns
module acr_sample_timer
(
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Control.
  input wire logic load_i,
  input wire logic [9:0] length_i,
  input wire logic tick_i,
  // Status.
  output logic done_o
);
  logic [9:0] left_reg;  // Converter clock periods still to sample.
  // Load a new length or count down on converter clock ticks.
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      left_reg <= 10'h000;
    else if (load_i)
      left_reg <= length_i;
    else if (tick_i && left_reg != 10'h000)
      left_reg <= left_reg - 10'h001;
  end
  assign done_o = left_reg == 10'h000;
endmodule : acr_sample_timer

// [hw/acr_regs.sv]
// Top of the converter control and trigger register block with its APB slave.
// What this block does
// - Ready flag follows references, zero when off.
// - Fault flag sets on fault, clears off-ready.
// - Scan-done sets on scan end, clears on read.
// - Three-bit capacitor divider, 2.5 pF steps.
// - Ten-bit shared sample time in converter periods.
// - Status flags raise interrupt when enabled.
// - External requests accepted when enable set.
// - Seven-bit ratio divides control clock; zero reserved.
// - Two-bit converter source clock select.
// - Control clock period is code plus one.
// - Separate digital enables for both cores.
// - Reference code zero is supply; others reserved.
// - Suspend blocks all new triggers.
// - Update-ready when suspended and idle; interrupt.
// - Software sample wins, ignores sample time.
// - Software sample drives shared sampling and class 2/3.
// - Request converts selected input, self-clears.
// - Level trigger holds; edge trigger self-clears.
// - Dedicated core input alternate select.
// - Dedicated presync triggers and synchronous sampling.
// - Module enable turns converter on and off.
`timescale 1ns/1ns
module acr_regs
(
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // APB slave port.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Analog status from the reference and scan logic.
  input wire logic bandgap_ready_i,
  input wire logic vref_ready_i,
  input wire logic ref_fault_i,
  input wire logic scan_complete_i,
  input wire logic core_busy_i,
  // External conversion request interface.
  input wire logic ext_request_i,
  input wire logic [5:0] ext_input_i,
  // Controls toward the analog cores.
  output logic module_on_o,
  output logic [1:0] conv_clk_source_o,
  output logic control_clk_tick_o,
  output logic shared_clk_tick_o,
  output logic [2:0] cap_divider_setting_o,
  output logic [2:0] ref_select_o,
  output logic shared_core_dig_en_o,
  output logic dedicated_core_dig_en_o,
  output logic shared_sampling_o,
  output logic class23_connect_o,
  output logic convert_start_o,
  output logic [5:0] convert_input_o,
  output logic global_level_trig_o,
  output logic global_edge_trig_o,
  output logic [5:0] dedicated_input_o,
  output logic dedicated_presync_trig_o,
  output logic dedicated_sync_sampling_o,
  output logic ref_reserved_o,
  output logic irq_o
);
  // Register storage.
  logic [31:0] ctrl_two_reg;    // Control register two.
  logic [31:0] ctrl_three_reg;  // Control register three.
  logic [31:0] trig_mode_reg;   // Dedicated core trigger mode.
  logic module_on_reg;          // Module enable.
  logic [31:0] prdata_reg;      // Registered read data.
  logic irq_reg;                // Registered interrupt.
  logic [31:0] ctrl_two_next;
  logic [31:0] ctrl_three_next;
  // Bus decode.
  wire access_w = psel_i && penable_i;
  wire wr_w = access_w && pwrite_i;
  wire rd_w = access_w && !pwrite_i;
  wire hit_two_w = paddr_i == acr_pkg::OFF_CTRL_TWO;
  wire hit_three_w = paddr_i == acr_pkg::OFF_CTRL_THREE;
  wire hit_mode_w = paddr_i == acr_pkg::OFF_TRIG_MODE;
  wire hit_on_w = paddr_i == acr_pkg::OFF_MODULE_CTRL;
  wire mapped_w = hit_two_w || hit_three_w || hit_mode_w || hit_on_w;
  wire [31:0] bytemask_w = {{8{pstrb_i[3]}}, {8{pstrb_i[2]}}, {8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
  // Reading the top status byte clears the scan-done flag.
  wire scan_read_w = rd_w && hit_two_w;
  // Status inputs.
  wire ref_ok_w = bandgap_ready_i && vref_ready_i;
  wire ready_set_w = module_on_reg && ref_ok_w && !ctrl_two_reg[acr_pkg::CT2_READY];
  wire fault_set_w = module_on_reg && ref_fault_i && !ctrl_two_reg[acr_pkg::CT2_FAULT];
  wire scan_set_w = scan_complete_i && !ctrl_two_reg[acr_pkg::CT2_SCAN];
  // Clock dividers share one interface type.
  acr_tick_if ctl_tk();
  acr_tick_if shr_tk();
  assign ctl_tk.ratio = {1'b0, ctrl_three_reg[acr_pkg::CT3_CDIV_LO +: 6]};
  assign ctl_tk.enable = module_on_reg;
  // Shared clock divides control ticks; ratio zero is reserved and treated as one.
  wire [6:0] ratio_w = ctrl_two_reg[6:0];
  assign shr_tk.ratio = (ratio_w == 7'h00) ? 7'h00 : ratio_w - 7'h01;
  assign shr_tk.enable = module_on_reg && ctl_tk.tick;
  // Control clock divider.
  acr_divider u_ctl_div
  (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .tk(ctl_tk)
  );
  // Shared converter clock divider, clocked by control ticks.
  acr_divider u_shr_div
  (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .tk(shr_tk)
  );
  wire shr_tick_w = shr_tk.tick;
  // Trigger gating: suspend blocks all starts.
  wire suspend_w = ctrl_three_reg[acr_pkg::CT3_SUSPEND];
  wire trig_ok_w = module_on_reg && !suspend_w;
  wire sw_req_w = ctrl_three_reg[acr_pkg::CT3_REQUEST];
  wire ext_req_w = ctrl_two_reg[acr_pkg::CT2_EXT_EN] && ext_request_i;
  wire sw_sample_w = ctrl_three_reg[acr_pkg::CT3_SAMPLE];
  // Shared core sampling state machine.
  acr_pkg::acr_state_e state_reg;
  acr_pkg::acr_state_e state_next;
  logic sw_sample_hold_done_w;
  wire start_w = trig_ok_w && (sw_req_w || ext_req_w) && shr_tick_w;
  wire load_w = state_reg == acr_pkg::ACR_IDLE && start_w;
  // Sample window timer in shared converter clock periods.
  acr_sample_timer u_sw_sample_hold
  (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .load_i(load_w),
    .length_i(ctrl_two_reg[acr_pkg::CT2_SW_SAMPLE_HOLD_LO +: 10]),
    .tick_i(shr_tick_w),
    .done_o(sw_sample_hold_done_w)
  );
  // Next-state selection.
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      acr_pkg::ACR_IDLE:
        if (load_w)
          state_next = acr_pkg::ACR_SAMPLE;
      acr_pkg::ACR_SAMPLE:
        // Software sample holds sampling and overrides the timer.
        if (!sw_sample_w && sw_sample_hold_done_w)
          state_next = acr_pkg::ACR_CONVERT;
      acr_pkg::ACR_CONVERT:
        if (shr_tick_w)
          state_next = acr_pkg::ACR_IDLE;
      default:
        state_next = acr_pkg::ACR_IDLE;
    endcase
  end
  // Busy means any core converting or the shared core out of idle.
  wire busy_w = core_busy_i || state_reg != acr_pkg::ACR_IDLE;
  wire upd_set_w = suspend_w && !busy_w;
  // Next value of control register two, with set winning over clear.
  always_comb
  begin
    ctrl_two_next = ctrl_two_reg;
    if (wr_w && hit_two_w)
      ctrl_two_next = (ctrl_two_reg & ~(acr_pkg::CT2_WMASK & bytemask_w))
        | (pwdata_i & acr_pkg::CT2_WMASK & bytemask_w);
    // Ready flag tracks the references and is zero while off.
    ctrl_two_next[acr_pkg::CT2_READY] = module_on_reg && ref_ok_w;
    // Fault flag sets on fault when on, clears when off with ready.
    if (module_on_reg && ref_fault_i)
      ctrl_two_next[acr_pkg::CT2_FAULT] = 1'b1;
    else if (!module_on_reg && ctrl_two_reg[acr_pkg::CT2_READY])
      ctrl_two_next[acr_pkg::CT2_FAULT] = 1'b0;
    // Scan-done sets on completion, a set in the reading cycle survives.
    if (scan_complete_i)
      ctrl_two_next[acr_pkg::CT2_SCAN] = 1'b1;
    else if (scan_read_w && pstrb_i[3] | !pwrite_i)
      ctrl_two_next[acr_pkg::CT2_SCAN] = 1'b0;
  end
  // Next value of control register three with self-clearing bits.
  always_comb
  begin
    ctrl_three_next = ctrl_three_reg;
    if (wr_w && hit_three_w)
      ctrl_three_next = (ctrl_three_reg & ~(acr_pkg::CT3_WMASK & bytemask_w))
        | (pwdata_i & acr_pkg::CT3_WMASK & bytemask_w);
    // Request and edge trigger clear on the next converter clock.
    if (shr_tick_w && !(wr_w && hit_three_w))
    begin
      ctrl_three_next[acr_pkg::CT3_REQUEST] = 1'b0;
      ctrl_three_next[acr_pkg::CT3_EDGE_TRG] = 1'b0;
    end
    // Update ready is driven by hardware only.
    ctrl_three_next[acr_pkg::CT3_UPD_RDY] = upd_set_w;
  end
  // Interrupt from any enabled flag as it sets.
  wire irq_next_w = (ready_set_w && ctrl_two_reg[acr_pkg::CT2_READY_IE])
    || (fault_set_w && ctrl_two_reg[acr_pkg::CT2_FAULT_IE])
    || (scan_set_w && ctrl_two_reg[acr_pkg::CT2_SCAN_IE])
    || (upd_set_w && !ctrl_three_reg[acr_pkg::CT3_UPD_RDY]
        && ctrl_three_reg[acr_pkg::CT3_UPD_IE]);
  // Read multiplexer.
  wire [31:0] rd_mux_w = hit_two_w ? ctrl_two_reg :
    hit_three_w ? ctrl_three_reg :
    hit_mode_w ? trig_mode_reg :
    hit_on_w ? {31'h0000_0000, module_on_reg} : 32'h0000_0000;
  // Register update process.
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_two_reg <= acr_pkg::REG_RESET;
      ctrl_three_reg <= acr_pkg::REG_RESET;
      trig_mode_reg <= acr_pkg::REG_RESET;
      module_on_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      irq_reg <= 1'b0;
      state_reg <= acr_pkg::ACR_IDLE;
    end
    else
    begin
      ctrl_two_reg <= ctrl_two_next;
      ctrl_three_reg <= ctrl_three_next;
      irq_reg <= irq_next_w;
      state_reg <= state_next;
      if (wr_w && hit_mode_w)
        trig_mode_reg <= (trig_mode_reg & ~(acr_pkg::TM_WMASK & bytemask_w))
          | (pwdata_i & acr_pkg::TM_WMASK & bytemask_w);
      if (wr_w && hit_on_w && pstrb_i[0])
        module_on_reg <= pwdata_i[0];
      if (rd_w)
        prdata_reg <= rd_mux_w;
    end
  end
  // Bus answers: zero wait, error on unmapped address.
  assign pready_o = 1'b1;
  assign pslverr_o = access_w && !mapped_w;
  assign prdata_o = rd_w ? rd_mux_w : prdata_reg;
  // Clock and reference controls.
  assign module_on_o = module_on_reg;
  assign conv_clk_source_o = ctrl_three_reg[acr_pkg::CT3_SRC_LO +: 2];
  assign control_clk_tick_o = ctl_tk.tick;
  assign shared_clk_tick_o = shr_tick_w;
  assign cap_divider_setting_o = ctrl_two_reg[acr_pkg::CT2_CAP_LO +: 3];
  assign ref_select_o = ctrl_three_reg[acr_pkg::CT3_REF_LO +: 3];
  assign ref_reserved_o = ref_select_o != acr_pkg::REF_SUPPLY;
  // Core enables.
  assign shared_core_dig_en_o = module_on_reg && ctrl_three_reg[acr_pkg::CT3_SHARED_EN];
  assign dedicated_core_dig_en_o = module_on_reg && ctrl_three_reg[acr_pkg::CT3_DED_EN];
  // Sampling and conversion controls.
  assign shared_sampling_o = state_reg == acr_pkg::ACR_SAMPLE || (module_on_reg && sw_sample_w);
  assign class23_connect_o = module_on_reg && sw_sample_w;
  assign convert_start_o = load_w;
  assign convert_input_o = ext_req_w ? ext_input_i : ctrl_three_reg[5:0];
  assign global_level_trig_o = trig_ok_w && ctrl_three_reg[acr_pkg::CT3_LEVEL_TRG];
  assign global_edge_trig_o = trig_ok_w && ctrl_three_reg[acr_pkg::CT3_EDGE_TRG];
  // Dedicated core options.
  assign dedicated_input_o = trig_mode_reg[acr_pkg::TM_ALT_LO +: 2] == acr_pkg::ALT_INPUT_HIGH
    ? acr_pkg::DED_INPUT_HIGH : acr_pkg::DED_INPUT_ZERO;
  assign dedicated_presync_trig_o = trig_mode_reg[acr_pkg::TM_PRESYNC];
  assign dedicated_sync_sampling_o = trig_mode_reg[acr_pkg::TM_SYNC_SW_SAMPLE_HOLD];
  assign irq_o = irq_reg;
endmodule : acr_regs

// [verification/acr_regs_sva.sv]
// Checker of port-level relations of the converter control register block.
`timescale 1ns/1ns
module acr_regs_sva
(
  // Clock, reset and bus.
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pslverr_o,
  // Core side.
  input wire logic core_busy_i,
  input wire logic module_on_o,
  input wire logic shared_clk_tick_o,
  input wire logic [2:0] ref_select_o,
  input wire logic ref_reserved_o,
  input wire logic shared_core_dig_en_o,
  input wire logic convert_start_o,
  input wire logic global_level_trig_o,
  input wire logic global_edge_trig_o,
  input wire logic [5:0] dedicated_input_o
);
  // All properties share the one clock and its reset.
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);
  // Read access phases to control two and three, and any read past the map.
  wire rd_two = psel_i & penable_i & ~pwrite_i & (paddr_i == acr_pkg::OFF_CTRL_TWO);
  wire rd_three = psel_i & penable_i & ~pwrite_i & (paddr_i == acr_pkg::OFF_CTRL_THREE);
  wire rd_bad = psel_i & penable_i & ~pwrite_i & (paddr_i > acr_pkg::OFF_MODULE_CTRL);
  // Module held off for two cycles, and cores idle for two cycles.
  sequence s_off2;
    !module_on_o [*2];
  endsequence
  sequence s_idle2;
    !core_busy_i [*2];
  endsequence
  property p_ready_off;
    s_off2 ##0 rd_two |-> !prdata_o[31];
  endproperty
  property p_upd_set;
    s_idle2 ##0 (rd_three && prdata_o[12]) |-> prdata_o[10];
  endproperty
  property p_upd_clr;
    rd_three && !prdata_o[12] |-> !prdata_o[10];
  endproperty
  property p_start_on;
    convert_start_o |-> module_on_o || $past(module_on_o);
  endproperty
  property p_trig_on;
    (global_level_trig_o || global_edge_trig_o) |-> module_on_o;
  endproperty
  property p_alt;
    dedicated_input_o == acr_pkg::DED_INPUT_ZERO || dedicated_input_o == acr_pkg::DED_INPUT_HIGH;
  endproperty
  property p_ref;
    ref_reserved_o == (ref_select_o != acr_pkg::REF_SUPPLY);
  endproperty
  property p_dig;
    shared_core_dig_en_o |-> module_on_o;
  endproperty
  property p_tick;
    shared_clk_tick_o |-> module_on_o || $past(module_on_o);
  endproperty
  property p_bad;
    rd_bad |-> pslverr_o && prdata_o == 32'h0000_0000;
  endproperty
  a_ready_off: assert property (p_ready_off) else $error("ready flag seen while off");
  a_upd_set: assert property (p_upd_set) else $error("update ready missing");
  a_upd_clr: assert property (p_upd_clr) else $error("update ready without suspend");
  a_start_on: assert property (p_start_on) else $error("start while off");
  a_trig_on: assert property (p_trig_on) else $error("global trigger while off");
  a_alt: assert property (p_alt) else $error("bad dedicated input");
  a_ref: assert property (p_ref) else $error("reserved reference flag wrong");
  a_dig: assert property (p_dig) else $error("digital enable while off");
  a_tick: assert property (p_tick) else $error("shared tick while off");
  a_bad: assert property (p_bad) else $error("unmapped read not refused");
endmodule : acr_regs_sva
bind acr_regs acr_regs_sva u_sva (.*);

// [verification/acr_core_model.sv]
// Behavioural model of the analog cores, references and external requester.
`timescale 1ns/1ns
module acr_core_model
(
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Controls from the block and commands from the bench.
  input wire logic module_on_i,
  input wire logic convert_start_i,
  input wire logic fault_cmd_i,
  input wire logic [5:0] ext_cmd_i,
  // Status toward the block.
  output logic bandgap_ready_o,
  output logic vref_ready_o,
  output logic ref_fault_o,
  output logic core_busy_o,
  output logic ext_request_o,
  output logic [5:0] ext_input_o
);
  logic [2:0] warm_cnt; // Reference warm-up age since enable.
  logic [2:0] busy_cnt; // Remaining conversion cycles.
  // References settle some cycles after enable; each start keeps a core busy.
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i || !module_on_i) warm_cnt <= 3'h0;
    else if (warm_cnt != 3'h7) warm_cnt <= warm_cnt + 3'h1;
    if (!rst_n_i) busy_cnt <= 3'h0;
    else if (convert_start_i) busy_cnt <= 3'h4;
    else if (busy_cnt != 3'h0) busy_cnt <= busy_cnt - 3'h1;
  end
  // The band gap is ready before the reference, so the flag needs both.
  assign bandgap_ready_o = warm_cnt > 3'h3;
  assign vref_ready_o = warm_cnt > 3'h5;
  assign ref_fault_o = fault_cmd_i;
  assign core_busy_o = busy_cnt != 3'h0;
  // The requester only raises a proper request with a valid input number.
  assign ext_request_o = ext_cmd_i != 6'h00;
  assign ext_input_o = ext_cmd_i;
endmodule : acr_core_model

// [verification/acr_regs_tb.sv]
// Self-checking testbench of the converter control register block.
`timescale 1ns/1ns
module acr_regs_tb;
  localparam logic [31:0] DIV = 32'h0100_0000; // Control clock code one.
  logic mclk_i = 1'b0, rst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, q;
  logic [3:0] pstrb_i = 4'hF;
  logic bandgap_ready_i, vref_ready_i, ref_fault_i, core_busy_i, ext_request_i;
  logic scan_complete_i = 1'b0, fault_cmd = 1'b0, err;
  logic [5:0] ext_input_i, ext_cmd = 6'h00, convert_input_o, dedicated_input_o;
  logic pready_o, pslverr_o, module_on_o, control_clk_tick_o, shared_clk_tick_o;
  logic [1:0] conv_clk_source_o;
  logic [2:0] cap_divider_setting_o, ref_select_o;
  logic shared_core_dig_en_o, dedicated_core_dig_en_o, shared_sampling_o, class23_connect_o;
  logic convert_start_o, global_level_trig_o, global_edge_trig_o, dedicated_presync_trig_o;
  logic dedicated_sync_sampling_o, ref_reserved_o, irq_o;
  int n_mismatch = 0, total_checks = 0, irqs = 0, i0, t0, t1, c0, c1, n;
  // Clock of 50 ns period.
  always #25 mclk_i = ~mclk_i;
  // Interrupt pulses are counted as they come.
  always @(posedge mclk_i) if (irq_o === 1'b1) irqs++;
  acr_regs DUT (.*);
  acr_core_model u_model (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .module_on_i(module_on_o),
    .convert_start_i(convert_start_o), .fault_cmd_i(fault_cmd), .ext_cmd_i(ext_cmd),
    .bandgap_ready_o(bandgap_ready_i), .vref_ready_o(vref_ready_i),
    .ref_fault_o(ref_fault_i), .core_busy_o(core_busy_i),
    .ext_request_o(ext_request_i), .ext_input_o(ext_input_i));
  // Compares a value and reports a mismatch.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer: setup, then access held until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel_i <= 1'b1; penable_i <= 1'b0; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    q = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0; penable_i <= 1'b0;
  endtask : apb
  // Lets some edges pass and samples just after one.
  task automatic idle(input int c);
    repeat (c) @(posedge mclk_i);
    #1;
  endtask : idle
  // Waits a bounded time for a conversion start.
  task automatic wait_start;
    n = 0;
    do @(posedge mclk_i); while (convert_start_o !== 1'b1 && ++n < 60);
    chk(convert_start_o, 1'b1);
  endtask : wait_start
  task automatic t_reset;
    apb(0, 8'h00, 0); chk(q, acr_pkg::REG_RESET);
    apb(0, 8'h04, 0); chk(q, acr_pkg::REG_RESET);
    apb(0, 8'h08, 0); chk(q, acr_pkg::REG_RESET);
    apb(1, 8'h10, 32'hFFFF_FFFF);
    apb(0, 8'h10, 0); chk({q[30:0], err}, 32'h1);
    $display("reset test done");
  endtask : t_reset
  task automatic t_fields;
    apb(1, 8'h00, 32'hFFFF_FFFF); apb(0, 8'h00, 0); chk(q, acr_pkg::CT2_WMASK);
    idle(1); chk(cap_divider_setting_o, 3'h7);
    apb(1, 8'h04, 32'hFFFF_FFFF); apb(0, 8'h04, 0); chk(q, 32'hFF81_FFFF);
    idle(1); chk({conv_clk_source_o, ref_select_o, ref_reserved_o}, 6'h3F);
    apb(1, 8'h08, 32'hFFFF_FFFF); apb(0, 8'h08, 0); chk(q, acr_pkg::TM_WMASK);
    idle(1); chk({dedicated_presync_trig_o, dedicated_sync_sampling_o}, 2'h3);
    apb(1, 8'h08, 32'h0001_0000); idle(1); chk(dedicated_input_o, 6'h2D);
    apb(1, 8'h08, 0); idle(1); chk(dedicated_input_o, 6'h00);
    apb(1, 8'h04, 0); idle(1); chk(ref_reserved_o, 1'b0);
    $display("field test done");
  endtask : t_fields
  task automatic t_ready;
    i0 = irqs;
    apb(1, 8'h00, 32'h0000_8001); apb(1, 8'h0C, 1); idle(1); chk(module_on_o, 1'b1);
    idle(12); apb(0, 8'h00, 0); chk(q[31], 1'b1);
    chk(irqs - i0, 1);
    apb(1, 8'h04, 32'h0080_0000); idle(1);
    chk({shared_core_dig_en_o, dedicated_core_dig_en_o}, 2'h2);
    apb(1, 8'h04, 32'h0001_0000); idle(1);
    chk({shared_core_dig_en_o, dedicated_core_dig_en_o}, 2'h1);
    $display("ready test done");
  endtask : t_ready
  task automatic t_fault_scan;
    i0 = irqs;
    apb(1, 8'h00, 32'h0000_4001); fault_cmd <= 1'b1; idle(3); fault_cmd <= 1'b0;
    apb(0, 8'h00, 0); chk(q[30], 1'b1);
    apb(1, 8'h0C, 0); apb(0, 8'h00, 0); chk(q[31:30], 2'h0);
    apb(1, 8'h0C, 1); apb(1, 8'h00, 32'h0000_2001); idle(12);
    scan_complete_i <= 1'b1; idle(1); scan_complete_i <= 1'b0;
    apb(0, 8'h00, 0); chk(q[29], 1'b1);
    apb(0, 8'h00, 0); chk(q[29], 1'b0);
    chk(irqs - i0, 2);
    $display("fault and scan test done");
  endtask : t_fault_scan
  task automatic t_convert;
    apb(1, 8'h00, 32'h0000_0002); apb(1, 8'h04, DIV); t0 = 0; t1 = 0; c0 = 0; c1 = 0;
    for (int i = 1; i < 40; i++)
    begin
      @(posedge mclk_i);
      if (shared_clk_tick_o === 1'b1) if (t0 == 0) t0 = i; else if (t1 == 0) t1 = i;
      if (control_clk_tick_o === 1'b1) if (c0 == 0) c0 = i; else if (c1 == 0) c1 = i;
    end
    chk(c1 - c0, 2);
    chk(t1 - t0, 4);
    apb(1, 8'h04, DIV | 32'h0000_0115); wait_start; chk(convert_input_o, 6'h15);
    idle(4); apb(0, 8'h04, 0); chk(q[8], 1'b0);
    apb(1, 8'h04, DIV | 32'h0000_1000); idle(6); apb(0, 8'h04, 0); chk(q[10], 1'b1);
    apb(1, 8'h04, DIV | 32'h0000_1180); n = 0;
    repeat (30) @(posedge mclk_i) if (convert_start_o === 1'b1) n++;
    chk(n, 0);
    chk(global_level_trig_o, 1'b0);
    apb(1, 8'h04, DIV | 32'h0000_0080); idle(6); chk(global_level_trig_o, 1'b1);
    apb(1, 8'h04, DIV | 32'h0000_0040); @(posedge mclk_i); chk(global_edge_trig_o, 1'b1);
    idle(8); apb(0, 8'h04, 0); chk(q[7:6], 2'h0);
    $display("convert test done");
  endtask : t_convert
  task automatic t_sample_ext;
    apb(1, 8'h04, DIV | 32'h0000_0200); idle(1);
    chk({shared_sampling_o, class23_connect_o}, 2'h3);
    apb(1, 8'h04, DIV); idle(1); chk({shared_sampling_o, class23_connect_o}, 2'h0);
    // An external request with its enable set starts a conversion of the requested input.
    apb(1, 8'h00, 32'h0000_0802); ext_cmd <= 6'h2A; wait_start;
    chk(convert_input_o, 6'h2A);
    ext_cmd <= 6'h00;
    $display("sample and request test done");
  endtask : t_sample_ext
  // Closing task that prints the counts and the verdict.
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict
  // Watchdog well beyond the expected run length.
  initial
  begin
    #3000000;
    n_mismatch++;
    print_verdict;
  end
  // Main sequence: reset for six cycles, then every scenario.
  initial
  begin
    repeat (6) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    t_reset;
    t_fields;
    t_ready;
    t_fault_scan;
    t_convert;
    t_sample_ext;
    print_verdict;
  end
endmodule : acr_regs_tb
